// ### design/uart_irq_ctrl.sv
// Interrupt mask, source detection, clearing and priority encoding for the UART
`timescale 1ns/10ps
module uart_irq_ctrl (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // UART status and host accesses
  input wire uart_irq_pkg::uart_status_s stat,
  input wire uart_irq_pkg::host_access_s acc,
  // Results
  output logic irq,
  output logic sleep_en,
  output logic [7:0] line_status
);
  import uart_irq_pkg::*;

  // ************************************************************
  // Registers and bus state
  // ************************************************************
  logic [7:0] mask;
  logic [7:0] ctrl;
  logic aw_full;
  logic w_full;
  logic [3:0] aw_addr;
  logic [7:0] w_data;
  logic w_lane0;
  logic do_write;
  logic rd_take;
  logic src_read;
  logic line_read;
  logic [7:0] src_val;
  logic fifo_en;
  logic efr_on;
  logic [5:0] rx_trig;
  logic [5:0] tx_trig;

  assign fifo_en = ctrl[CTRL_FIFO_EN];
  assign efr_on = ctrl[CTRL_ENHANCED];
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign do_write = aw_full && w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign src_read = rd_take && s_axi_araddr == ADDR_SOURCE;
  assign line_read = rd_take && s_axi_araddr == ADDR_LINE;

  // ************************************************************
  // Write channel
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == ADDR_MASK || aw_addr == ADDR_CTRL || aw_addr == ADDR_SOURCE
          || aw_addr == ADDR_LINE) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Upper mask bits are locked unless the enhanced bit is on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask <= MASK_RESET;
    end else if (do_write && w_lane0 && aw_addr == ADDR_MASK) begin
      mask[3:0] <= w_data[3:0];
      if (efr_on) begin
        mask[7:4] <= w_data[7:4];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
    end else if (do_write && w_lane0 && aw_addr == ADDR_CTRL) begin
      ctrl <= w_data;
    end
  end

  assign sleep_en = mask[4] && efr_on;

  // ************************************************************
  // Trigger levels
  // ************************************************************
  always_comb begin
    case (ctrl[CTRL_RX_TRIG_LO +: 2])
      2'd0: rx_trig = RX_TRIG0;
      2'd1: rx_trig = RX_TRIG1;
      2'd2: rx_trig = RX_TRIG2;
      default: rx_trig = RX_TRIG3;
    endcase
    case (ctrl[CTRL_TX_TRIG_LO +: 2])
      2'd0: tx_trig = TX_TRIG0;
      2'd1: tx_trig = TX_TRIG1;
      2'd2: tx_trig = TX_TRIG2;
      default: tx_trig = TX_TRIG3;
    endcase
  end

  // ************************************************************
  // Line status
  // ************************************************************
  logic overrun_seen;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_seen <= 1'b0;
    end else if (stat.overrun) begin
      overrun_seen <= 1'b1;
    end else if (line_read) begin
      overrun_seen <= 1'b0;
    end
  end

  assign line_status = {stat.fifo_err, stat.thr_empty && stat.tsr_empty, stat.thr_empty,
                        stat.head_err, overrun_seen, stat.rx_level != 6'd0};

  // ************************************************************
  // Source flags; a set in the clear cycle wins
  // ************************************************************
  logic ls_flag;
  logic ls_set;
  logic [2:0] head_q;
  assign ls_set = stat.overrun
    || (ctrl[CTRL_ERR_ON_RX] ? |stat.rx_err : |(stat.head_err & ~head_q));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      head_q <= 3'b000;
      ls_flag <= 1'b0;
    end else begin
      head_q <= stat.head_err;
      if (ls_set) begin
        ls_flag <= 1'b1;
      end else if (line_read) begin
        ls_flag <= 1'b0;
      end
    end
  end

  // Receive ready is a level, so host reads below the trigger clear it
  logic rx_pend;
  assign rx_pend = fifo_en ? stat.rx_level >= rx_trig : stat.rx_level != 6'd0;

  // Transmit ready: edge of the empty condition or of its enable
  logic tx_cond;
  logic tx_cond_q;
  logic tx_en_q;
  logic tx_flag;
  logic tx_set;
  always_comb begin
    if (ctrl[CTRL_HALF_DUPLEX]) begin
      tx_cond = stat.thr_empty && stat.tsr_empty;
    end else if (fifo_en) begin
      tx_cond = stat.tx_level < tx_trig || stat.tx_level == 6'd0;
    end else begin
      tx_cond = stat.thr_empty;
    end
  end
  assign tx_set = (tx_cond && !tx_cond_q) || (tx_cond && mask[1] && !tx_en_q);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Starts high so leaving reset with an empty transmitter is no edge
      tx_cond_q <= 1'b1;
      tx_en_q <= 1'b0;
      tx_flag <= 1'b0;
    end else begin
      tx_cond_q <= tx_cond;
      tx_en_q <= mask[1];
      if (tx_set) begin
        tx_flag <= 1'b1;
      end else if (src_read || acc.thr_write) begin
        tx_flag <= 1'b0;
      end
    end
  end

  // Modem and flow-control change flags
  logic ms_flag;
  logic flow_flag;
  logic [3:0] delta_q;
  logic flow_set;
  assign flow_set = (stat.rts_rise && stat.auto_rts) || (stat.cts_rise && stat.auto_cts);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      delta_q <= 4'h0;
      ms_flag <= 1'b0;
      flow_flag <= 1'b0;
    end else begin
      delta_q <= stat.modem_delta;
      if (|(stat.modem_delta & ~delta_q)) begin
        ms_flag <= 1'b1;
      end else if (acc.msr_read) begin
        ms_flag <= 1'b0;
      end
      if (flow_set) begin
        flow_flag <= 1'b1;
      end else if (acc.msr_read) begin
        flow_flag <= 1'b0;
      end
    end
  end

  // Xoff, special character, and the Xoff hold shown on source bit 4
  logic xoff_flag;
  logic spec_flag;
  logic xoff_hold;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xoff_flag <= 1'b0;
      spec_flag <= 1'b0;
      xoff_hold <= 1'b0;
    end else begin
      if (stat.xoff_det) begin
        xoff_flag <= 1'b1;
        xoff_hold <= 1'b1;
      end else begin
        if (src_read || stat.xon_det) begin
          xoff_flag <= 1'b0;
        end
        if (stat.xon_det) begin
          xoff_hold <= 1'b0;
        end
      end
      if (stat.special_det) begin
        spec_flag <= 1'b1;
      end else if (src_read || stat.rx_char) begin
        spec_flag <= 1'b0;
      end
    end
  end

  // Wake indication after leaving sleep
  logic wake_flag;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_flag <= 1'b0;
    end else if (stat.sleep_exit) begin
      wake_flag <= 1'b1;
    end else if (src_read) begin
      wake_flag <= 1'b0;
    end
  end

  // ************************************************************
  // Receive time-out timer, restarted by each character or read
  // ************************************************************
  logic [7:0] to_count;
  logic [7:0] to_limit;
  logic to_hit;
  logic to_flag;
  assign to_limit = 8'(TIMEOUT_CHARS * {4'h0, stat.char_bits}) + TIMEOUT_BITS;
  assign to_hit = fifo_en && stat.bit_tick && stat.rx_level != 6'd0 && to_count == to_limit - 8'd1;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      to_count <= 8'h00;
    end else if (stat.rx_char || acc.rhr_read || stat.rx_level == 6'd0 || to_hit) begin
      to_count <= 8'h00;
    end else if (stat.bit_tick) begin
      to_count <= to_count + 8'd1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      to_flag <= 1'b0;
    end else if (to_hit) begin
      to_flag <= 1'b1;
    end else if (acc.rhr_read) begin
      to_flag <= 1'b0;
    end
  end

  // ************************************************************
  // Priority encoding and interrupt output
  // ************************************************************
  logic [6:0] pend;
  assign pend = {flow_flag && efr_on && (mask[6] || mask[7]),
                 (xoff_flag || spec_flag) && efr_on && mask[5],
                 ms_flag && mask[3],
                 tx_flag && mask[1],
                 rx_pend && mask[0],
                 to_flag && mask[0],
                 ls_flag && mask[2]};

  // Only the top pending level is shown; the rest stay queued in their flags except tx_flag, xoff_flag and spec_flag, which a source read clears
  logic [5:0] src_code;
  always_comb begin
    if (pend[0]) begin
      src_code = SRC_LINE;
    end else if (pend[1]) begin
      src_code = SRC_TIMEOUT;
    end else if (pend[2]) begin
      src_code = SRC_RX;
    end else if (pend[3]) begin
      src_code = SRC_TX;
    end else if (pend[4]) begin
      src_code = SRC_MODEM;
    end else if (pend[5]) begin
      src_code = SRC_XOFF;
    end else if (pend[6]) begin
      src_code = SRC_FLOW;
    end else begin
      src_code = SRC_NONE;
    end
  end

  assign src_val = {{2{fifo_en}},
                    src_code[5], src_code[4] || (xoff_hold && efr_on), src_code[3:1],
                    src_code[0] || wake_flag};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |pend;
    end
  end

  // ************************************************************
  // Read channel; a read of a source clears its flags above
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr == ADDR_MASK) begin
        s_axi_rdata <= {24'h00_0000, mask};
      end else if (s_axi_araddr == ADDR_SOURCE) begin
        s_axi_rdata <= {24'h00_0000, src_val};
      end else if (s_axi_araddr == ADDR_LINE) begin
        s_axi_rdata <= {24'h00_0000, line_status};
      end else if (s_axi_araddr == ADDR_CTRL) begin
        s_axi_rdata <= {24'h00_0000, ctrl};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  rx_trig_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (fifo_en && mask[0] && stat.rx_level >= rx_trig) |=> irq)
    else $error("receive trigger did not raise interrupt");
  lock_upper_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && aw_addr == ADDR_MASK && !efr_on) |=> $stable(mask[7:4]))
    else $error("upper mask bits changed while locked");
  overrun_ls_a: assert property (@(posedge aclk) disable iff (!aresetn)
    stat.overrun |=> ls_flag)
    else $error("overrun did not set line status flag");
  tx_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (acc.thr_write && !tx_set) |=> !tx_flag)
    else $error("transmit ready not cleared");
  tx_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(mask[1]) && tx_cond) |=> ##1 irq)
    else $error("enabling transmit ready while empty gave no interrupt");
  idle_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!irq && !wake_flag && !(xoff_hold && efr_on) && $past(pend) == 7'h00
     && pend == 7'h00) |-> src_val[5:0] == SRC_NONE)
    else $error("idle source code wrong");
  top_line_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ls_flag && mask[2]) |-> src_val[3:1] == SRC_LINE[3:1])
    else $error("line status not top priority");
  timeout_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (to_hit || (to_flag && !acc.rhr_read)) |=> to_flag)
    else $error("time-out flag not held");
  modem_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (acc.msr_read && !flow_set && stat.modem_delta == 4'h0) |=> !flow_flag && !ms_flag)
    else $error("modem status read did not clear");
endmodule : uart_irq_ctrl

// ### design/uart_irq_pkg.sv
// Constants, register map and carrier structs for the UART interrupt block
// Overview of operation
// - FIFO mode, mask bit 0: receive interrupt at trigger level, cleared below it
// - Line status bit 0 set when a character enters FIFO, cleared when empty
// - Line status: overrun, head errors, holding empty, transmitter empty, FIFO error
// - Mask bit 0 gates receive ready; holding register full or trigger reached
// - Mask bit 1 gates transmit ready; enabling while empty raises it at once
// - Mask bit 2 gates line status interrupt; overrun raises it on reception
// - Parity, framing, break interrupt at read position or on reception by option bit
// - Mask bit 3 gates modem status interrupt from any modem delta bit
// - Mask bit 4 is sleep; bits 4 to 7 writable only with enhanced bit set
// - Mask bit 5 gates Xoff or special; source bit 4 holds until Xon
// - Mask bits 6 and 7 gate flow-control rises; source bit 5 shows them
// - Receive time-out after four characters plus 12 bits; receive read clears it
// - Transmit ready from trigger and FIFO empty, or transmitter empty in half duplex
// - Line status read clears line interrupt; receive ready clears below trigger
// - Source read or transmit holding write clears transmit ready
// - Modem status read clears modem and flow-control change interrupts
// - Xoff clears on source read or Xon; special on source read or next character
// - Leaving sleep sets wake indication, source bit 0 high, source read clears it
// - Source bit 0 is 0 when pending unless the wake indication is set, 1 when idle, idle after reset
// - Source read shows only the highest pending level; others stay queued except transmit ready, Xoff and special, which it clears
// - Source codes per level: 06, 0c, 04, 02, 00, 10, 20
// - Source bits 7 and 6 follow the FIFO enable
// - Receive trigger codes 0 to 3 select 8, 16, 24, 28 characters
package uart_irq_pkg;
  localparam logic [3:0] ADDR_MASK = 4'h0;
  localparam logic [3:0] ADDR_SOURCE = 4'h4;
  localparam logic [3:0] ADDR_LINE = 4'h8;
  localparam logic [3:0] ADDR_CTRL = 4'hc;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Control register fields
  localparam int CTRL_FIFO_EN = 0;
  localparam int CTRL_TX_TRIG_LO = 1;
  localparam int CTRL_RX_TRIG_LO = 3;
  localparam int CTRL_ERR_ON_RX = 5;
  localparam int CTRL_HALF_DUPLEX = 6;
  localparam int CTRL_ENHANCED = 7;
  // Interrupt source codes, bits 5 to 0
  localparam logic [5:0] SRC_NONE = 6'h01;
  localparam logic [5:0] SRC_LINE = 6'h06;
  localparam logic [5:0] SRC_TIMEOUT = 6'h0c;
  localparam logic [5:0] SRC_RX = 6'h04;
  localparam logic [5:0] SRC_TX = 6'h02;
  localparam logic [5:0] SRC_MODEM = 6'h00;
  localparam logic [5:0] SRC_XOFF = 6'h10;
  localparam logic [5:0] SRC_FLOW = 6'h20;
  // Trigger tables
  localparam logic [5:0] RX_TRIG0 = 6'd8;
  localparam logic [5:0] RX_TRIG1 = 6'd16;
  localparam logic [5:0] RX_TRIG2 = 6'd24;
  localparam logic [5:0] RX_TRIG3 = 6'd28;
  localparam logic [5:0] TX_TRIG0 = 6'd16;
  localparam logic [5:0] TX_TRIG1 = 6'd8;
  localparam logic [5:0] TX_TRIG2 = 6'd24;
  localparam logic [5:0] TX_TRIG3 = 6'd30;
  localparam logic [7:0] TIMEOUT_CHARS = 8'd4;
  localparam logic [7:0] TIMEOUT_BITS = 8'd12;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Status from receiver, transmitter and flow control
  typedef struct packed {
    logic [5:0] rx_level;
    logic rx_char;
    logic [2:0] head_err;
    logic [2:0] rx_err;
    logic fifo_err;
    logic overrun;
    logic thr_empty;
    logic tsr_empty;
    logic [5:0] tx_level;
    logic [3:0] modem_delta;
    logic xoff_det;
    logic special_det;
    logic xon_det;
    logic rts_rise;
    logic cts_rise;
    logic auto_rts;
    logic auto_cts;
    logic sleep_exit;
    logic bit_tick;
    logic [3:0] char_bits;
  } uart_status_s;

  // Host accesses to registers kept outside this block
  typedef struct packed {
    logic rhr_read;
    logic thr_write;
    logic msr_read;
  } host_access_s;
endpackage : uart_irq_pkg

// ### verif/axi_host_model.sv
// Host processor model speaking AXI4-Lite to the interrupt block
`timescale 1ns/10ps
module axi_host_model (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [3:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic [3:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // Address and data offered together, each released when taken
  task wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_open;
    logic w_open;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_open = 1'b1;
    w_open = 1'b1;
    while (aw_open || w_open) begin
      @(posedge aclk);
      if (aw_open && awready) begin
        awvalid <= 1'b0;
        aw_open = 1'b0;
      end
      if (w_open && wready) begin
        wvalid <= 1'b0;
        w_open = 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    d = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : axi_host_model

// ### verif/uart_interrupt_enable_and_priority_tb.sv
// Self-checking bench for the UART interrupt block
`timescale 1ns/10ps
module uart_interrupt_enable_and_priority_tb;
  import uart_irq_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr, araddr, wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, rsp;
  uart_status_s stat;
  host_access_s acc;
  logic irq, sleep_en;
  logic [7:0] line_status, rd_d;
  logic [31:0] lfsr = 32'hc3b2;
  int error_cnt = 0;
  int n_tests = 0;
  int pend[$];
  int trig_tab[4] = '{8, 16, 24, 28};

  always #4 aclk = ~aclk;

  uart_irq_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .stat(stat), .acc(acc), .irq(irq), .sleep_en(sleep_en),
    .line_status(line_status));

  axi_host_model i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  // ****************************************
  // Reference model and checks
  // ****************************************
  function automatic logic [31:0] rand_step();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rand_step

  // Highest pending level wins; the rest stay queued in pend
  function automatic logic [7:0] exp_src(bit fifo);
    int codes[7] = '{6, 12, 4, 2, 0, 16, 32};
    int lv = 8;
    foreach (pend[i]) if (pend[i] < lv) lv = pend[i];
    return {fifo ? 2'b11 : 2'b00, (lv == 8) ? 6'h01 : 6'(codes[lv - 1])};
  endfunction : exp_src

  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task chk_flag(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask : chk_flag

  task rd_src(input bit fifo);
    i_host.rd(ADDR_SOURCE, rd_d, rsp);
    chk_byte(rd_d, exp_src(fifo));
  endtask : rd_src

  task wait_n(input int n);
    repeat (n) @(posedge aclk);
  endtask : wait_n

  task tick();
    @(posedge aclk) stat.bit_tick <= 1'b1;
    @(posedge aclk) stat.bit_tick <= 1'b0;
  endtask : tick

  task test_done();
    $display("tests=%0d errors=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // Generous bound; the sequence needs only a few hundred cycles
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    stat = '0;
    stat.thr_empty = 1'b1;
    stat.tsr_empty = 1'b1;
    stat.char_bits = 4'h1;
    acc = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    i_host.rd(ADDR_MASK, rd_d, rsp);
    chk_byte(rd_d, MASK_RESET);
    rd_src(0);
    chk_flag(irq, 1'b0);
    $display("reset test done");
    i_host.wr(ADDR_MASK, 8'h02, rsp);
    wait_n(2);
    chk_flag(irq, 1'b1);
    pend = '{4};
    rd_src(0);
    pend.delete();
    rd_src(0);
    wait_n(2);
    chk_flag(irq, 1'b0);
    @(posedge aclk) stat.thr_empty <= 1'b0;
    @(posedge aclk) stat.thr_empty <= 1'b1;
    wait_n(3);
    chk_flag(irq, 1'b1);
    @(posedge aclk) acc.thr_write <= 1'b1;
    @(posedge aclk) acc.thr_write <= 1'b0;
    wait_n(2);
    chk_flag(irq, 1'b0);
    $display("transmit ready test done");
    i_host.wr(ADDR_CTRL, 8'h80, rsp);
    i_host.wr(ADDR_MASK, 8'hf0, rsp);
    i_host.rd(ADDR_MASK, rd_d, rsp);
    chk_byte(rd_d, 8'hf0);
    chk_flag(sleep_en, 1'b1);
    i_host.wr(ADDR_CTRL, 8'h00, rsp);
    i_host.wr(ADDR_MASK, 8'h00, rsp);
    i_host.rd(ADDR_MASK, rd_d, rsp);
    chk_byte(rd_d, 8'hf0);
    chk_flag(sleep_en, 1'b0);
    i_host.wr(ADDR_SOURCE, 8'hff, rsp);
    chk_byte({6'h00, rsp}, {6'h00, RESP_OKAY});
    rd_src(0);
    i_host.rd(4'h2, rd_d, rsp);
    chk_byte({6'h00, rsp}, {6'h00, RESP_SLVERR});
    $display("mask access test done");
    i_host.wr(ADDR_MASK, 8'h01, rsp);
    for (int c = 0; c < 4; c++) begin
      i_host.wr(ADDR_CTRL, 8'h01 | 8'(c << 3), rsp);
      stat.rx_level <= 6'(trig_tab[c] - 1);
      wait_n(2);
      rd_src(1);
      stat.rx_level <= 6'(trig_tab[c] + int'(rand_step() % 4));
      wait_n(2);
      pend = '{3};
      rd_src(1);
      chk_flag(irq, 1'b1);
      chk_byte(line_status, 8'h61);
      stat.rx_level <= 6'(trig_tab[c] - 1);
      wait_n(2);
      pend.delete();
      rd_src(1);
    end
    $display("receive trigger test done");
    i_host.wr(ADDR_CTRL, 8'h01, rsp);
    i_host.wr(ADDR_MASK, 8'h05, rsp);
    stat.rx_level <= 6'd10;
    @(posedge aclk) stat.overrun <= 1'b1;
    @(posedge aclk) stat.overrun <= 1'b0;
    wait_n(2);
    pend = '{1, 3};
    rd_src(1);
    rd_src(1);
    chk_byte(line_status, 8'h63);
    i_host.rd(ADDR_LINE, rd_d, rsp);
    chk_byte(rd_d, 8'h63);
    pend = '{3};
    rd_src(1);
    stat.rx_level <= 6'd0;
    $display("line status test done");
    i_host.wr(ADDR_MASK, 8'h08, rsp);
    stat.modem_delta <= 4'h1;
    wait_n(2);
    pend = '{5};
    rd_src(1);
    chk_flag(irq, 1'b1);
    stat.modem_delta <= 4'h0;
    @(posedge aclk) acc.msr_read <= 1'b1;
    @(posedge aclk) acc.msr_read <= 1'b0;
    wait_n(2);
    pend.delete();
    rd_src(1);
    chk_flag(irq, 1'b0);
    $display("modem test done");
    i_host.wr(ADDR_MASK, 8'h01, rsp);
    stat.rx_level <= 6'd1;
    repeat (15) tick();
    wait_n(2);
    rd_src(1);
    tick();
    wait_n(2);
    pend = '{2};
    rd_src(1);
    @(posedge aclk) acc.rhr_read <= 1'b1;
    @(posedge aclk) acc.rhr_read <= 1'b0;
    wait_n(2);
    pend.delete();
    rd_src(1);
    $display("time-out test done");
    i_host.wr(ADDR_CTRL, 8'h81, rsp);
    i_host.wr(ADDR_MASK, 8'h60, rsp);
    @(posedge aclk) stat.xoff_det <= 1'b1;
    @(posedge aclk) stat.xoff_det <= 1'b0;
    wait_n(2);
    pend = '{6};
    rd_src(1);
    pend.delete();
    i_host.rd(ADDR_SOURCE, rd_d, rsp);
    chk_byte(rd_d, exp_src(1) | 8'h10);
    @(posedge aclk) stat.xon_det <= 1'b1;
    @(posedge aclk) stat.xon_det <= 1'b0;
    wait_n(2);
    rd_src(1);
    @(posedge aclk) stat.special_det <= 1'b1;
    @(posedge aclk) stat.special_det <= 1'b0;
    wait_n(2);
    chk_flag(irq, 1'b1);
    @(posedge aclk) stat.rx_char <= 1'b1;
    @(posedge aclk) stat.rx_char <= 1'b0;
    wait_n(2);
    chk_flag(irq, 1'b0);
    stat.auto_rts <= 1'b1;
    @(posedge aclk) stat.rts_rise <= 1'b1;
    @(posedge aclk) stat.rts_rise <= 1'b0;
    wait_n(2);
    pend = '{7};
    rd_src(1);
    @(posedge aclk) acc.msr_read <= 1'b1;
    @(posedge aclk) acc.msr_read <= 1'b0;
    wait_n(2);
    pend.delete();
    rd_src(1);
    @(posedge aclk) begin
      stat.sleep_exit <= 1'b1;
      stat.special_det <= 1'b1;
    end
    @(posedge aclk) begin
      stat.sleep_exit <= 1'b0;
      stat.special_det <= 1'b0;
    end
    wait_n(2);
    pend = '{6};
    i_host.rd(ADDR_SOURCE, rd_d, rsp);
    chk_byte(rd_d, exp_src(1) | 8'h01);
    pend.delete();
    rd_src(1);
    $display("enhanced test done");
    i_host.wr(ADDR_CTRL, 8'ha1, rsp);
    i_host.wr(ADDR_MASK, 8'h04, rsp);
    @(posedge aclk) stat.rx_err <= 3'b001;
    @(posedge aclk) stat.rx_err <= 3'b000;
    wait_n(2);
    pend = '{1};
    rd_src(1);
    i_host.rd(ADDR_LINE, rd_d, rsp);
    chk_byte(rd_d, 8'h61);
    pend.delete();
    rd_src(1);
    $display("error on reception test done");
    test_done();
  end
endmodule : uart_interrupt_enable_and_priority_tb
